/* sdifr_pkg.sv */
// Package: constants and types of the rate converter input block
package sdifr_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int SW = 24;   // Sample word and serial slot width
  localparam int TSW = 24;  // Timestamp width
  localparam int NSRC = 8;  // Stereo sources in the pool
  localparam int NSTR = 5;  // Converter streams
  localparam int NCH = 6;   // Converter streams plus direct input
  localparam int NFLG = 13; // Flags F0..F12
  localparam int NPAD = 6;  // Shared pads F6..F11
  localparam int SELW = 3;  // Source select field width
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_ROUTE = 8'h00;
  localparam logic [7:0] OFS_FMT = 8'h04;
  localparam logic [7:0] OFS_FCTL = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_TS0 = 8'h10;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int FC_EN = 0;   // F0..F5 enables
  localparam int FC_DIR = 6;  // F6..F12 direction, 1 = out
  localparam int FC_STR = 13; // F6..F12 stretch, 1 = on
  localparam logic [17:0] ROUTE_RST = 18'h2C688;
  localparam logic [5:0] FMT_RST = 6'h00;
  localparam logic [19:0] FCTL_RST = 20'h0003F;
  // ----------------------------------------
  // Sources and formats
  // ----------------------------------------
  localparam logic [2:0] SRC_I2S1 = 3'h0;
  localparam logic [2:0] SRC_I2S4 = 3'h3;
  localparam logic [2:0] SRC_SPDIF1 = 3'h4; // spdif1_disc_ch34_input
  localparam logic [2:0] SRC_SPDIF2 = 3'h5; // spdif2_disc_ch56_input
  localparam logic [2:0] SRC_TUNER1 = 3'h6;
  localparam logic [2:0] SRC_TUNER2 = 3'h7;
  localparam logic FMT_I2S = 1'b0;
  localparam logic FMT_LJ = 1'b1;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [SW-1:0] l;
    logic [SW-1:0] r;
  } sdifr_stereo_t;
  typedef struct packed {
    logic bck;
    logic ws;
    logic sd;
  } sdifr_ser_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } sdifr_req_t;
endpackage : sdifr_pkg

/* sdifr_top.sv */
// Input routing, timestamps and flags around the rate converter core
`timescale 1ns/1ps
module sdifr_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Host register port
  input sdifr_pkg::sdifr_req_t host_req,
  output logic [31:0] host_rdata,
  // Audio DSP control write port
  input sdifr_pkg::sdifr_req_t adsp_req,
  // Serial sources from pins
  input sdifr_pkg::sdifr_ser_t [7:0] src_ser,
  // Stereo outputs, index 5 is the direct input
  output sdifr_pkg::sdifr_stereo_t [5:0] chan_data,
  output logic [5:0] chan_valid,
  // Reference rate tick
  input wire logic ref_tick,
  // Flags of the rate_converter_dsp
  output logic [12:0] dsp_flags,
  input wire logic flag_rd,
  input wire logic [12:6] dsp_fout,
  // Audio DSP share of the pads
  input wire logic [5:0] adsp_fout,
  input wire logic [5:0] adsp_fdir,
  // Shared user flag pads
  input wire logic [5:0] pad_i,
  output logic [5:0] pad_o,
  output logic [5:0] pad_oe,
  // Watchdog flag
  input wire logic watchdog_unit_fin,
  output logic watchdog_unit_flag
);
  import sdifr_pkg::*;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [17:0] route_r;
  logic [5:0] fmt_r;
  logic [19:0] fctl_r;
  logic [TSW-1:0] ts_cnt_r;
  logic [TSW-1:0] ts_r [NCH];
  logic [5:0] pad_s1_r;
  logic [5:0] pad_s2_r;
  logic [NFLG-1:0] raw;
  logic [NFLG-1:0] str;

  // Write hits of both writers
  wire h_wr = host_req.wr;
  wire a_wr = adsp_req.wr;
  wire h_rt = h_wr && host_req.addr == OFS_ROUTE;
  wire a_rt = a_wr && adsp_req.addr == OFS_ROUTE;
  wire h_fm = h_wr && host_req.addr == OFS_FMT;
  wire a_fm = a_wr && adsp_req.addr == OFS_FMT;
  wire h_fc = h_wr && host_req.addr == OFS_FCTL;
  wire a_fc = a_wr && adsp_req.addr == OFS_FCTL;
  wire [17:0] route_nxt = a_rt ? adsp_req.wdata[17:0] :
    h_rt ? host_req.wdata[17:0] : route_r;
  wire [5:0] fmt_nxt = a_fm ? adsp_req.wdata[5:0] :
    h_fm ? host_req.wdata[5:0] : fmt_r;
  wire [19:0] fctl_nxt = a_fc ? adsp_req.wdata[19:0] :
    h_fc ? host_req.wdata[19:0] : fctl_r;

  // Register update, audio DSP wins a same-cycle clash
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      route_r <= ROUTE_RST;
      fmt_r <= FMT_RST;
      fctl_r <= FCTL_RST;
    end else begin
      route_r <= route_nxt;
      fmt_r <= fmt_nxt;
      fctl_r <= fctl_nxt;
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  wire [7:0] ra = host_req.addr;
  wire [7:0] ts_off = ra - OFS_TS0;
  wire ts_hit = ra >= OFS_TS0 && ts_off[7:2] < 6'(NCH)
    && ra[1:0] == 2'h0;
  wire [31:0] ts_rd = ts_hit ? 32'(ts_r[ts_off[4:2]]) : 32'h0;
  wire [31:0] rmux =
    ra == OFS_ROUTE ? 32'(route_r) :
    ra == OFS_FMT ? 32'(fmt_r) :
    ra == OFS_FCTL ? 32'(fctl_r) :
    ra == OFS_STAT ? {13'h0, pad_s2_r, dsp_flags} : ts_rd;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      host_rdata <= 32'h0;
    end else begin
      host_rdata <= host_req.rd ? rmux : 32'h0;
    end
  end

  // ----------------------------------------
  // Source synchronisers
  // ----------------------------------------
  sdifr_ser_t [7:0] src_s1_r;
  sdifr_ser_t [7:0] src_s2_r;

  // Two flops on every source pin and pad
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      src_s1_r <= '0;
      src_s2_r <= '0;
      pad_s1_r <= 6'h00;
      pad_s2_r <= 6'h00;
    end else begin
      src_s1_r <= src_ser;
      src_s2_r <= src_s1_r;
      pad_s1_r <= pad_i;
      pad_s2_r <= pad_s1_r;
    end
  end

  // ----------------------------------------
  // Switchbox and deserialisers
  // ----------------------------------------
  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      logic bck_d_r;
      logic ws_d_r;
      logic [SW-1:0] sh_r;
      logic [SW-1:0] left_r;
      logic valid_r;
      sdifr_stereo_t data_r;
      // Source pick per input
      wire [2:0] sel = route_r[c*SELW +: SELW];
      wire sdifr_ser_t s = src_s2_r[sel];
      wire rise = s.bck && !bck_d_r;
      wire ws_chg = rise && (s.ws != ws_d_r);
      wire [SW-1:0] shin = {sh_r[SW-2:0], s.sd};
      // I2S word ends with this bit, left-justified before it
      wire [SW-1:0] word = fmt_r[c] == FMT_LJ ? sh_r : shin;

      // Shift on bit clock rise, close a word on select change
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          bck_d_r <= 1'b0;
          ws_d_r <= 1'b0;
          sh_r <= '0;
          left_r <= '0;
          valid_r <= 1'b0;
          data_r <= '0;
        end else begin
          bck_d_r <= s.bck;
          valid_r <= ws_chg && ws_d_r;
          if (rise) begin
            sh_r <= shin;
            ws_d_r <= s.ws;
          end
          if (ws_chg && !ws_d_r) begin
            left_r <= word;
          end
          if (ws_chg && ws_d_r) begin
            data_r <= {left_r, word};
          end
        end
      end

      // One driver per output slice, straight from the flops
      assign chan_valid[c] = valid_r;
      assign chan_data[c] = data_r;
    end
  endgenerate

  // ----------------------------------------
  // Timestamps
  // ----------------------------------------
  wire [NCH-1:0] ts_ev = {chan_valid[NSTR-1:0], ref_tick};

  // Free-running counter captured per stream sample and per reference tick
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ts_cnt_r <= '0;
      for (int k = 0; k < NCH; k++) begin
        ts_r[k] <= '0;
      end
    end else begin
      ts_cnt_r <= ts_cnt_r + 1'b1;
      for (int k = 0; k < NCH; k++) begin
        if (ts_ev[k]) begin
          ts_r[k] <= ts_cnt_r;
        end
      end
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  wire [5:0] en = fctl_r[FC_EN +: 6];
  wire [6:0] dir = fctl_r[FC_DIR +: 7];
  wire [6:0] fstr = fctl_r[FC_STR +: 7];
  wire [5:0] my_out = dir[5:0] & dsp_fout[11:6];
  wire [5:0] oth_out = adsp_fdir & adsp_fout;
  wire [5:0] pad_o_nxt = my_out | oth_out;
  wire [5:0] pad_oe_nxt = dir[5:0] | adsp_fdir;

  // Raw flag sources and stretch modes
  always_comb begin
    raw[0] = ref_tick & en[0];
    raw[5:1] = chan_valid[NSTR-1:0] & en[5:1];
    raw[11:6] = ~dir[5:0] & pad_s2_r;
    raw[12] = ~dir[6] & watchdog_unit_fin;
    str = {fstr, 6'h3F};
  end

  wire [NFLG-1:0] hold = dsp_flags & ~{NFLG{flag_rd}};
  wire [NFLG-1:0] flag_nxt = raw | (str & hold);

  // Flag, pad and watchdog outputs
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dsp_flags <= '0;
      pad_o <= 6'h00;
      pad_oe <= 6'h00;
      watchdog_unit_flag <= 1'b0;
    end else begin
      dsp_flags <= flag_nxt;
      pad_o <= pad_o_nxt;
      pad_oe <= pad_oe_nxt;
      watchdog_unit_flag <= dir[6] & dsp_fout[12];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_ev1;
    chan_valid[0] && en[1];
  endsequence
  sequence s_held1;
    dsp_flags[1] && !flag_rd;
  endsequence

  AST_F1_SET: assert property (s_ev1 |=> dsp_flags[1])
    else $error("F1 not set by stream 1 sample");
  AST_F1_HOLD: assert property (s_held1 |=> dsp_flags[1])
    else $error("Stretched F1 dropped before read");
  AST_F0_SET: assert property ((ref_tick && en[0]) ##1 !flag_rd
    |=> dsp_flags[0])
    else $error("F0 not held after reference tick");
  AST_EN_OFF: assert property (!en[2] && !dsp_flags[2]
    |=> !dsp_flags[2])
    else $error("Disabled F2 was set");
  AST_PAD_OR: assert property (##1 pad_o == $past(pad_o_nxt)
    && (pad_o & ~pad_oe) == 6'h00)
    else $error("Pad driven high while not enabled");
  AST_PAD_IN: assert property (!dir[0] && !adsp_fdir[0]
    |=> !pad_oe[0])
    else $error("Pad driven though both set input");
  AST_WATCHDOG_UNIT: assert property (dir[6] && dsp_fout[12]
    |=> watchdog_unit_flag)
    else $error("Watchdog flag not driven");
  AST_TS1: assert property (chan_valid[0]
    |=> ts_r[1] == $past(ts_cnt_r))
    else $error("Stream 1 timestamp not captured");
  AST_ADSP_WR: assert property (a_rt |=> route_r ==
    $past(adsp_req.wdata[17:0]))
    else $error("Audio DSP route write lost");
  AST_RD_ZERO: assert property (!host_req.rd
    |=> host_rdata == 32'h0)
    else $error("Read data outside its cycle");
  AST_NOSTR: assert property (!fstr[0] && !dir[0]
    |=> dsp_flags[6] == $past(raw[6]))
    else $error("Unstretched F6 not following pad");
endmodule : sdifr_top

/* sdifr_src_model.sv */
// Behavioural model of the eight serial stereo sources feeding the block
`timescale 1ns/1ps
module sdifr_src_model (
  // Serial source pins
  output sdifr_pkg::sdifr_ser_t [7:0] ser
);
  import sdifr_pkg::*;
  initial ser = '0;
  // One frame, MSB first, bck stands still low between frames
  task automatic send(input int s, input logic [47:0] lr, input logic fmt);
    int sh;
    sh = (fmt == FMT_I2S) ? 1 : 0;
    for (int i = 0; i <= 48; i++) begin
      ser[s].ws = (i >= 24 && i < 48); // Left low, right high
      if (i - sh >= 0 && i - sh < 48) begin
        ser[s].sd = lr[47 - i + sh];
      end else begin
        ser[s].sd = ~ser[s].sd; // No stale bit outside the word
      end
      #40 ser[s].bck = 1'b1;
      #40 ser[s].bck = 1'b0;
    end
    ser[s].sd = ~ser[s].sd;
  endtask : send
endmodule : sdifr_src_model

/* test_src_dsp_input_flag_routing.sv */
// Self-checking testbench of routing, formats, flags and pads
`timescale 1ns/1ps
module test_src_dsp_input_flag_routing;
  import sdifr_pkg::*;
  logic core_clk, rstn, flag_rd, ref_tick, watchdog_unit_fin, watchdog_unit_flag;
  sdifr_req_t host_req, adsp_req;
  sdifr_ser_t [7:0] src_ser;
  sdifr_stereo_t [5:0] chan_data;
  logic [31:0] host_rdata;
  logic [12:0] dsp_flags;
  logic [12:6] dsp_fout;
  logic [5:0] chan_valid, adsp_fout, adsp_fdir, pad_i, pad_o, pad_oe;
  logic [5:0] pad_ext, seen, m, eo, ew;
  logic [47:0] exp_lr;
  logic [17:0] rt;
  logic [6:0] dir;
  int num_errors, checked, cyc;
  // Pad wire level from both drivers
  assign pad_i = (pad_oe & pad_o) | (~pad_oe & pad_ext);
  sdifr_top DUT (.core_clk(core_clk), .rstn(rstn), .host_req(host_req),
    .host_rdata(host_rdata), .adsp_req(adsp_req), .src_ser(src_ser),
    .chan_data(chan_data), .chan_valid(chan_valid), .ref_tick(ref_tick),
    .dsp_flags(dsp_flags), .flag_rd(flag_rd), .dsp_fout(dsp_fout),
    .adsp_fout(adsp_fout), .adsp_fdir(adsp_fdir), .pad_i(pad_i),
    .pad_o(pad_o), .pad_oe(pad_oe), .watchdog_unit_fin(watchdog_unit_fin),
    .watchdog_unit_flag(watchdog_unit_flag));
  sdifr_src_model src (.ser(src_ser));
  // ----------------------------------------
  // Compare, bus and flag tasks
  // ----------------------------------------
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_reg
  task automatic chk_dat(input logic [47:0] g, input logic [47:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_dat
  task automatic wr(input bit dsp, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    if (dsp) adsp_req <= '{1'b1, 1'b0, a, d};
    else host_req <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    host_req.wr <= 1'b0;
    adsp_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    host_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge core_clk);
    host_req.rd <= 1'b0;
    #1 chk_reg(host_rdata, e);
  endtask : rd
  task automatic pulse(input bit fr);
    @(posedge core_clk);
    if (fr) flag_rd <= 1'b1;
    else ref_tick <= 1'b1;
    @(posedge core_clk);
    flag_rd <= 1'b0;
    ref_tick <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : pulse
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // Clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  // Every new stereo sample is compared with the frame sent
  always @(posedge core_clk) begin
    for (int k = 0; k < NCH; k++) begin
      if (rstn && chan_valid[k] === 1'b1) begin
        seen[k] = 1'b1;
        chk_dat(chan_data[k], exp_lr);
      end
    end
  end
  // Main sequence
  initial begin
    {host_req, adsp_req, flag_rd, ref_tick, watchdog_unit_fin} = '0;
    {dsp_fout, adsp_fout, adsp_fdir, pad_ext, rstn} = '0;
    void'($urandom(32'hF4F2936C));
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    rd(OFS_ROUTE, {14'h0, ROUTE_RST});
    rd(OFS_FMT, 32'h0);
    rd(OFS_FCTL, {12'h0, FCTL_RST});
    rd(8'h3C, 32'h0);
    for (int p = 0; p < 2; p++) begin
      rt = 18'($urandom);
      wr(p[0], OFS_ROUTE, {14'h0, rt});
      wr(p[0], OFS_FMT, {26'h0, {6{p[0]}}});
      rd(OFS_ROUTE, {14'h0, rt});
      for (int s = 0; s < NSRC; s++) begin
        exp_lr = 48'({$urandom, $urandom});
        for (int k = 0; k < NCH; k++) m[k] = (rt[3*k +: 3] == 3'(s));
        seen = '0;
        #3 src.send(s, exp_lr, p[0]);
        repeat (10) @(posedge core_clk);
        chk_reg(seen, m);
        chk_reg(dsp_flags[5:1], m[4:0]);
        pulse(1'b1);
        chk_reg(dsp_flags[5:1], 0);
      end
    end
    pulse(1'b0);
    chk_reg(dsp_flags[0], 1);
    pulse(1'b1);
    chk_reg(dsp_flags[0], 0);
    wr(0, OFS_FCTL, 32'h3E);
    pulse(1'b0);
    chk_reg(dsp_flags[0], 0);
    for (int n = 0; n < 8; n++) begin
      dir = 7'($urandom);
      wr(0, OFS_FCTL, {13'h0, dir, 6'h3F});
      {adsp_fout, adsp_fdir, pad_ext, dsp_fout, watchdog_unit_fin} <= 26'($urandom);
      repeat (6) @(posedge core_clk);
      eo = dir[5:0] | adsp_fdir;
      ew = (dsp_fout[11:6] & dir[5:0]) | (adsp_fout & adsp_fdir);
      chk_reg(pad_oe, eo);
      chk_reg(pad_o, ew);
      chk_reg(dsp_flags[12:6], 7'(~dir & {watchdog_unit_fin, eo & ew | ~eo & pad_ext}));
      chk_reg(watchdog_unit_flag, dir[6] & dsp_fout[12]);
    end
    wr(0, OFS_FCTL, 32'h0203F);
    {adsp_fdir, pad_ext} <= '0;
    wr(0, OFS_FMT, 32'h0);
    pulse(1'b1);
    chk_reg(dsp_flags[6], 0);
    pad_ext <= 6'h01;
    repeat (2) @(posedge core_clk);
    pad_ext <= 6'h00;
    repeat (6) @(posedge core_clk);
    chk_reg(dsp_flags[6], 1);
    pulse(1'b1);
    chk_reg(dsp_flags[6], 0);
    final_report();
  end
endmodule : test_src_dsp_input_flag_routing
